// *** rtl/imu_pkg.sv ***
// Purpose: Constants and carrier types for the inertial output register set.
// Assumes: 125 MHz clock, classic Wishbone slave, 32-bit data, one word per register.
// Notes:   Byte address of a register is four times its index.
//
// Overview of operation
// - Z acceleration high word is 16-bit two's complement, 1.25 mg per count.
// - Separate z acceleration low word carries extra resolution below the high word.
// - Temperature word is two's complement, 0.1 degree per count, zero at 0 C.
// - Time stamp holds offset-binary time since last timing pulse, 49.02 us per count.
// - Time stamp is meaningful only when control bits 4 to 2 equal 010.
// - Each update's time stamp marks its last sample relative to latest timing edge.
// - Update counter clears to zero at power-on and after a reset command.
// - Update counter increments once per output load, offset binary.
// - Update counter wraps from its maximum to zero and keeps counting.
// - Delta angle sums adjacent rate pairs over the window, scaled by one over 2fs.
// - Samples per delta angle result equal the decimation setting plus one.
// - Internal sample clock runs at a nominal 2000 samples per second.
// - Each axis delta angle is one 32-bit value split into high and low words.
// - Delta angle high word counts 2160 degrees over two to the fifteenth.
// - Y delta angle low word sits just below the y high word address.
// - Acceleration high and low words form one 32-bit two's complement value.
package imu_pkg;
   localparam int unsigned CLK_HZ     = 125_000_000;
   localparam int unsigned INT_SPS    = 2000;
   localparam int unsigned SAMPLE_NS  = 1_000_000_000 / INT_SPS;
   localparam int unsigned SAMPLE_CYC = SAMPLE_NS * (CLK_HZ / 1_000_000) / 1000;
   localparam int unsigned TS_LSB_NS  = 49_020;
   localparam int unsigned TS_CYC     = TS_LSB_NS * (CLK_HZ / 1_000_000) / 1000;
   // Rate LSB 0.1 deg/s to 2160/2^31 deg, times 1/(2*2000), in 8 fraction bits.
   localparam logic [13:0] ANG_K      = 14'h18db;
   localparam logic [7:0] IDX_ZA_LO   = 8'h18;
   localparam logic [7:0] IDX_ZA_HI   = 8'h1a;
   localparam logic [7:0] IDX_TEMP    = 8'h1c;
   localparam logic [7:0] IDX_TS      = 8'h1e;
   localparam logic [7:0] IDX_CNT     = 8'h22;
   localparam logic [7:0] IDX_XA_LO   = 8'h24;
   localparam logic [7:0] IDX_XA_HI   = 8'h26;
   localparam logic [7:0] IDX_YA_LO   = 8'h28;
   localparam logic [7:0] IDX_YA_HI   = 8'h2a;
   localparam logic [7:0] IDX_CMD     = 8'h3e;
   localparam logic [7:0] IDX_MISC    = 8'h60;
   localparam logic [7:0] IDX_DEC     = 8'h64;
   localparam int unsigned MODE_LSB   = 2;
   localparam logic [2:0] MODE_SCALED = 3'h2;
   localparam logic [15:0] MISC_RST   = 16'h0000;
   localparam logic [15:0] DEC_RST    = 16'h0000;
   localparam int unsigned CMD_RST_BIT = 0;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [9:0]  adr;
      logic [31:0] dat;
      logic [3:0]  sel;
   } imu_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } imu_wb_rsp_t;

   typedef struct packed {
      logic [1:0][15:0] rate;
      logic [31:0]      accel_z;
      logic [15:0]      temp;
   } imu_sens_t;

   typedef struct packed {
      logic             ack;
      logic [31:0]      rdat;
      logic [15:0]      misc;
      logic [15:0]      dec;
      logic [16:0]      tick_cnt;
      logic [10:0]      dec_cnt;
      logic [1:0][15:0] prev;
      logic [1:0][27:0] acc;
      logic [12:0]      ts_pre;
      logic [15:0]      ts_cnt;
      logic [31:0]      accel;
      logic [15:0]      temp;
      logic [15:0]      ts;
      logic [15:0]      cnt;
      logic [1:0][31:0] dang;
      logic             s1;
      logic             s2;
      logic             s3;
      logic             drdy;
   } imu_state_t;
endpackage

// *** rtl/imu_out_regs.sv ***
// Purpose: Output data registers with trapezoidal delta-angle integration.
// Assumes: Sensor words arrive on clk; the timing pin is asynchronous.
// Notes:   Sampling always uses the internal sample tick.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
module imu_out_regs #(
   parameter int unsigned SAMPLE_CYC = imu_pkg::SAMPLE_CYC,
   parameter int unsigned TS_CYC     = imu_pkg::TS_CYC
) (
   input  wire logic                 clk,                 // 125 MHz clock
   input  wire logic                 rst_b,               // Async reset, low
   input  wire imu_pkg::imu_wb_req_t wb_req,              // Wishbone request
   output imu_pkg::imu_wb_rsp_t      wb_rsp,              // Wishbone answer
   input  wire imu_pkg::imu_sens_t   sens,                // Raw sensor words
   input  wire logic                 sync_pin,            // External timing input
   output logic                      sample_ready_output  // Pulse per output load
);
   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_m_q;
   logic rst_s_b;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_m_q <= 1'b0;
         rst_s_b <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_s_b <= rst_m_q;
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] ang_scale(input logic signed [27:0] s);
      logic signed [41:0] p;
      p = 42'(s) * $signed({1'b0, imu_pkg::ANG_K});
      return p[39:8];
   endfunction

   function automatic logic [15:0] lane_wr(input logic [15:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) r[7:0] = dat[7:0];
      if (sel[1]) r[15:8] = dat[15:8];
      return r;
   endfunction

   // ------------------------------------------------------------
   // State update
   // ------------------------------------------------------------
   imu_pkg::imu_state_t     q;
   imu_pkg::imu_state_t     d;
   logic [7:0]              idx;
   logic                    req;
   logic                    tick;
   logic                    load;
   logic                    mode_ss;
   logic                    sync_edge;
   logic                    cmd_rst;
   logic signed [1:0][27:0] sum;

   assign idx       = wb_req.adr[9:2];
   assign req       = wb_req.cyc & wb_req.stb & ~q.ack;
   assign tick      = q.tick_cnt == 17'(SAMPLE_CYC - 1);
   assign load      = tick & (q.dec_cnt >= q.dec[10:0]);
   assign mode_ss   = q.misc[imu_pkg::MODE_LSB +: 3] == imu_pkg::MODE_SCALED;
   assign sync_edge = q.s2 & ~q.s3;
   assign cmd_rst   = req & wb_req.we & (idx == imu_pkg::IDX_CMD) & wb_req.sel[0]
                      & wb_req.dat[imu_pkg::CMD_RST_BIT];

   for (genvar i = 0; i < 2; i++) begin : g_sum
      assign sum[i] = $signed(q.acc[i]) + 28'($signed(sens.rate[i]))
                      + 28'($signed(q.prev[i]));
   end

   always_comb begin
      d      = q;
      d.ack  = 1'b0;
      d.drdy = 1'b0;
      d.s1   = sync_pin;
      d.s2   = q.s1;
      d.s3   = q.s2;
      d.tick_cnt = tick ? 17'h00000 : q.tick_cnt + 17'h00001;
      // Time since the latest timing edge, only counted in scaled mode.
      if (!mode_ss || sync_edge) begin
         d.ts_pre = 13'h0000;
         d.ts_cnt = 16'h0000;
      end else if (q.ts_pre == 13'(TS_CYC - 1)) begin
         d.ts_pre = 13'h0000;
         d.ts_cnt = q.ts_cnt + 16'h0001;
      end else begin
         d.ts_pre = q.ts_pre + 13'h0001;
      end
      if (tick) begin
         d.dec_cnt = load ? 11'h000 : q.dec_cnt + 11'h001;
         for (int i = 0; i < 2; i++) begin
            d.prev[i] = sens.rate[i];
            d.acc[i]  = load ? 28'h0000000 : sum[i];
            if (load) d.dang[i] = ang_scale(sum[i]);
         end
      end
      // Every output word of one update is loaded in the same edge.
      if (load) begin
         d.accel = sens.accel_z;
         d.temp  = sens.temp;
         d.ts    = q.ts_cnt;
         d.cnt   = q.cnt + 16'h0001;
         d.drdy  = 1'b1;
      end
      // Bus access; output words ignore writes.
      if (req) begin
         d.ack = 1'b1;
         unique case (idx)
            imu_pkg::IDX_ZA_LO: d.rdat = {16'h0000, q.accel[15:0]};
            imu_pkg::IDX_ZA_HI: d.rdat = {16'h0000, q.accel[31:16]};
            imu_pkg::IDX_TEMP:  d.rdat = {16'h0000, q.temp};
            imu_pkg::IDX_TS:    d.rdat = {16'h0000, q.ts};
            imu_pkg::IDX_CNT:   d.rdat = {16'h0000, q.cnt};
            imu_pkg::IDX_XA_LO: d.rdat = {16'h0000, q.dang[0][15:0]};
            imu_pkg::IDX_XA_HI: d.rdat = {16'h0000, q.dang[0][31:16]};
            imu_pkg::IDX_YA_LO: d.rdat = {16'h0000, q.dang[1][15:0]};
            imu_pkg::IDX_YA_HI: d.rdat = {16'h0000, q.dang[1][31:16]};
            imu_pkg::IDX_MISC:  d.rdat = {16'h0000, q.misc};
            imu_pkg::IDX_DEC:   d.rdat = {16'h0000, q.dec};
            default:            d.rdat = 32'h00000000;
         endcase
         if (wb_req.we) begin
            if (idx == imu_pkg::IDX_MISC) d.misc = lane_wr(q.misc, wb_req.dat, wb_req.sel);
            if (idx == imu_pkg::IDX_DEC)  d.dec  = lane_wr(q.dec, wb_req.dat, wb_req.sel);
         end
      end
      // A reset command restarts counting and integration.
      if (cmd_rst) begin
         d.cnt     = 16'h0000;
         d.dec_cnt = 11'h000;
         d.acc     = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_s_b) begin
      if (!rst_s_b) begin
         q      <= '0;
         q.misc <= imu_pkg::MISC_RST;
         q.dec  <= imu_pkg::DEC_RST;
      end else begin
         q <= d;
      end
   end

   assign wb_rsp.ack          = q.ack;
   assign wb_rsp.dat          = q.rdat;
   assign sample_ready_output = q.drdy;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_s_b);

   sequence s_load;
      load && !cmd_rst;
   endsequence
   sequence s_quiet8;
      !tick [*8];
   endsequence

   property p_cnt_inc;
      s_load |=> q.cnt == 16'($past(q.cnt) + 16'h0001) && q.drdy;
   endproperty
   a_cnt_inc: assert property (p_cnt_inc) else $error("Counter did not step by one.");

   property p_cnt_wrap;
      s_load and (q.cnt == 16'hffff) |=> q.cnt == 16'h0000;
   endproperty
   a_cnt_wrap: assert property (p_cnt_wrap) else $error("Counter did not wrap.");

   property p_cmd_clr;
      cmd_rst |=> q.cnt == 16'h0000 && q.dec_cnt == 11'h000;
   endproperty
   a_cmd_clr: assert property (p_cmd_clr) else $error("Reset command left count.");

   property p_pair;
      s_load |=> q.accel == $past(sens.accel_z) && q.temp == $past(sens.temp)
                 && q.ts == $past(q.ts_cnt);
   endproperty
   a_pair: assert property (p_pair) else $error("Update words not loaded together.");

   property p_dang;
      tick && load |=> q.dang[0] == ang_scale($past(sum[0]))
                       && q.acc[0] == 28'h0000000;
   endproperty
   a_dang: assert property (p_dang) else $error("Delta angle result wrong.");

   property p_win;
      q.drdy |-> q.dec_cnt == 11'h000;
   endproperty
   a_win: assert property (p_win) else $error("Window length wrong.");

   property p_tick_gap;
      tick |=> s_quiet8;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("Sample ticks too close.");

   property p_ts_off;
      !mode_ss |=> q.ts_cnt == 16'h0000;
   endproperty
   a_ts_off: assert property (p_ts_off) else $error("Time stamp ran outside mode.");

   property p_ro;
      req && wb_req.we && !load && idx != imu_pkg::IDX_CMD |=> $stable(q.cnt)
                                                            && $stable(q.dang);
   endproperty
   a_ro: assert property (p_ro) else $error("Write changed an output word.");

endmodule // imu_out_regs

// *** tb/imu_sens_src.sv ***
// Purpose: Sensor front end model feeding raw words and the timing pin.
// Assumes: Words and the pin change only after a rising clock edge.
// Notes:   A timing pulse lasts two clocks so the synchroniser sees it.
`timescale 1ns/1ps
module imu_sens_src (
   input  wire logic          clk,      // Sample clock
   output imu_pkg::imu_sens_t sens,     // Raw sensor words
   output logic               sync_pin  // Timing pulse
);
   initial begin
      sens = '0;
      sync_pin = 1'b0;
   end
   task automatic set_words(input imu_pkg::imu_sens_t w);
      sens <= w;
   endtask
   task automatic pulse_sync();
      @(posedge clk);
      sync_pin <= 1'b1;
      repeat (2) @(posedge clk);
      sync_pin <= 1'b0;
   endtask
endmodule // imu_sens_src

// *** tb/test_imu_out_regs.sv ***
// Purpose: Self-checking bench for the output register set.
// Assumes: Short sample and stamp counts; sensor words held constant.
// Notes:   The driver queues notes; the monitor checks them on ack.
`timescale 1ns/1ps
module test_imu_out_regs;
   localparam int SC = 20;
   localparam int TC = 5;
   typedef struct {int kind; logic [31:0] exp; string nm;} imu_note_t;
   logic                 clk;
   logic                 rst_b;
   imu_pkg::imu_wb_req_t wb_req;
   imu_pkg::imu_wb_rsp_t wb_rsp;
   imu_pkg::imu_sens_t   sens;
   imu_pkg::imu_sens_t   w;
   logic                 sync_pin;
   logic                 sample_ready_output;
   imu_note_t            notes[$];
   imu_note_t            nt;
   int                   err_count;
   int                   checked;
   longint               cyc_n;
   longint               t_rdy;
   longint               t_prev;
   logic [31:0]          cap;

   imu_out_regs #(.SAMPLE_CYC(SC), .TS_CYC(TC)) u_imu_out_regs (.clk(clk), .rst_b(rst_b),
      .wb_req(wb_req), .wb_rsp(wb_rsp), .sens(sens), .sync_pin(sync_pin),
      .sample_ready_output(sample_ready_output));
   imu_sens_src u_imu_sens_src (.clk(clk), .sens(sens), .sync_pin(sync_pin));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) cyc_n <= cyc_n + 1;

   // ---------------------------------------------
   // Checking
   // ---------------------------------------------
   task automatic chk_word(input string nm, input logic [31:0] e, s, input logic ok);
      checked++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic chk_gap(input string nm, input longint e, s);
      checked++;
      if (e != s) begin
         err_count++;
         $display("CHECK FAILED %s expected %0d seen %0d", nm, e, s);
      end
   endtask
   always @(posedge clk) begin
      if (wb_rsp.ack === 1'b1) begin
         nt = notes.pop_front();
         if (nt.kind == 2) cap = wb_rsp.dat;
         if (nt.kind == 1) chk_word(nt.nm, nt.exp, wb_rsp.dat, wb_rsp.dat === nt.exp);
         if (nt.kind == 3) chk_word(nt.nm, nt.exp, wb_rsp.dat, wb_rsp.dat <= nt.exp);
      end
   end
   task automatic conclude();
      if (err_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ---------------------------------------------
   // Driving
   // ---------------------------------------------
   task automatic wb(input logic we, input logic [7:0] idx, input logic [15:0] d,
                     input int kind, input logic [31:0] exp, input string nm);
      int n;
      notes.push_back('{kind, exp, nm});
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, dat: {16'h0, d},
                  sel: 4'h3};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wb_rsp.ack !== 1'b1 && n < 50);
      wb_req.cyc <= 1'b0;
      wb_req.stb <= 1'b0;
      if (n >= 50) begin
         err_count++;
         conclude();
      end
      @(posedge clk);
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (sample_ready_output !== 1'b1 && n < 500);
      if (n >= 500) begin
         err_count++;
         conclude();
      end
      t_prev = t_rdy;
      t_rdy = cyc_n;
   endtask
   // Four ticks of a constant rate give eight times the rate, then the angle scale.
   function automatic logic [31:0] ang(input logic [15:0] r);
      return (32'(r) * 32'd8 * 32'd6363) >> 8;
   endfunction

   initial begin
      void'($urandom(33567));
      {err_count, checked, cyc_n, t_rdy, t_prev, cap} = '0;
      rst_b = 1'b0;
      wb_req = '0;
      w.rate[0] = 16'($urandom % 1024);
      w.rate[1] = 16'($urandom % 1024);
      w.accel_z = $urandom;
      w.temp = 16'($urandom);
      u_imu_sens_src.set_words(w);
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge clk);
      wb(1, imu_pkg::IDX_DEC, 16'h0003, 0, '0, "");
      wb(0, 8'hff, 16'h0, 1, 32'h0, "unmapped");
      wait_rdy();
      wb(1, imu_pkg::IDX_CMD, 16'h0001, 0, '0, "");
      wb(0, imu_pkg::IDX_CNT, 16'h0, 1, 32'h0, "count cleared");
      wb(1, imu_pkg::IDX_ZA_HI, 16'hffff, 0, '0, "");
      wait_rdy();
      wb(0, imu_pkg::IDX_CNT, 16'h0, 1, 32'h1, "count");
      wb(0, imu_pkg::IDX_ZA_HI, 16'h0, 1, w.accel_z[31:16], "accel hi");
      wb(0, imu_pkg::IDX_ZA_LO, 16'h0, 1, w.accel_z[15:0], "accel lo");
      wb(0, imu_pkg::IDX_TEMP, 16'h0, 1, w.temp, "temp");
      wb(0, imu_pkg::IDX_XA_LO, 16'h0, 1, ang(w.rate[0]) & 32'hffff, "x lo");
      wb(0, imu_pkg::IDX_XA_HI, 16'h0, 1, ang(w.rate[0]) >> 16, "x hi");
      wb(0, imu_pkg::IDX_YA_LO, 16'h0, 1, ang(w.rate[1]) & 32'hffff, "y lo");
      wb(0, imu_pkg::IDX_YA_HI, 16'h0, 1, ang(w.rate[1]) >> 16, "y hi");
      wb(0, imu_pkg::IDX_TS, 16'h0, 1, 32'h0, "stamp off");
      wb(1, imu_pkg::IDX_MISC, 16'h0008, 0, '0, "");
      wait_rdy();
      chk_gap("load spacing", 4 * SC, t_rdy - t_prev);
      wb(0, imu_pkg::IDX_TS, 16'h0, 2, '0, "");
      wait_rdy();
      wb(0, imu_pkg::IDX_TS, 16'h0, 1, cap + 32'(4 * SC / TC), "stamp step");
      u_imu_sens_src.pulse_sync();
      wait_rdy();
      wb(0, imu_pkg::IDX_TS, 16'h0, 3, 32'(4 * SC / TC), "stamp restart");
      wb(1, imu_pkg::IDX_DEC, 16'h0000, 0, '0, "");
      wait_rdy();
      wait_rdy();
      chk_gap("ready period", SC, t_rdy - t_prev);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge clk);
      wb(0, imu_pkg::IDX_CNT, 16'h0, 1, 32'h0, "count after reset");
      wb(0, imu_pkg::IDX_DEC, 16'h0, 1, 32'(imu_pkg::DEC_RST), "dec after reset");
      conclude();
   end
endmodule // test_imu_out_regs
